// ---- design/rs_codec_map.vh ----
// constants for the sector reed-solomon codec: field, framing, timing
// assumes the includer works on 12-bit symbols over one clock domain
`ifndef RS_CODEC_MAP_VH
`define RS_CODEC_MAP_VH

// galois field gf(2^12), x^12 + x^6 + x^4 + x + 1
`define GF_POLY_LOW   12'h053
`define GF_ORDER      4095

// framing: 512 bytes make 342 data symbols, 6 check symbols follow
`define LAST_BYTE     9'h1ff
`define CHECK_SYMS    6
`define LAST_CHECK    3'h5
`define BM_LAST       3'h5
`define CHIEN_SPAN    347
`define LAST_POS      9'h15b
`define CORR_LIMIT    3'h3

// exponent giving the inverse: a^(4096-2)
`define INV_EXP       12'hffe
`define INV_BITS_TOP  4'hb

`endif

// ---- design/gf_inverse_unit.v ----
// sequential inverter in gf(2^12) by square-and-multiply
// assumes one start pulse at a time; operand zero returns zero
`include "rs_codec_map.vh"

module gf_inverse_unit (
    input  wire        core_clk,
    input  wire        reset,
    input  wire        start,
    input  wire [11:0] operand,
    output reg         done,
    output reg  [11:0] result
);

    localparam [11:0] inv_exp = `INV_EXP;

    reg        busy;     // walking exponent bits
    reg [3:0]  bit_idx;  // current exponent bit
    reg [11:0] acc;      // running power
    reg [11:0] base;     // captured operand
    reg [11:0] next_acc; // acc after this bit

    // shift-and-add multiply modulo the field polynomial
    function [11:0] gf_mul;
        input [11:0] a;
        input [11:0] b;
        reg   [11:0] p;
        reg   [11:0] x;
        integer      k;
        begin
            p = 12'h000;
            x = a;
            for (k = 0; k < 12; k = k + 1) begin
                if (b[k])
                    p = p ^ x;
                x = x[11] ? ({x[10:0], 1'b0} ^ `GF_POLY_LOW)
                          : {x[10:0], 1'b0};
            end
            gf_mul = p;
        end
    endfunction

    // square, then multiply when the exponent bit is set
    always @* begin
        next_acc = gf_mul(acc, acc);
        if (inv_exp[bit_idx])
            next_acc = gf_mul(next_acc, base);
    end

    // twelve steps, msb first; done pulses with the result
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            busy    <= 1'b0;
            bit_idx <= 4'h0;
            acc     <= 12'h001;
            base    <= 12'h000;
            done    <= 1'b0;
            result  <= 12'h000;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy    <= 1'b1;
                bit_idx <= `INV_BITS_TOP;
                acc     <= 12'h001;
                base    <= operand;
            end else if (busy) begin
                acc     <= next_acc;
                bit_idx <= bit_idx - 4'h1;
                if (bit_idx == 4'h0) begin
                    busy   <= 1'b0;
                    done   <= 1'b1;
                    result <= next_acc;
                end
            end
        end
    end

endmodule // gf_inverse_unit

// ---- design/sector_reed_solomon_codec.v ----
// reed-solomon codec for one 512-byte sector: encoder and decoder
// assumes bytes arrive in order and the caller waits on byte_ready;
// corrections are reported as symbol index and xor value, not applied
`include "rs_codec_map.vh"

module sector_reed_solomon_codec (
    input  wire        core_clk,
    input  wire        reset,
    input  wire        decode_mode,
    input  wire        byte_valid,
    input  wire [7:0]  byte_data,
    output wire        byte_ready,
    input  wire [71:0] code_in,
    output reg  [71:0] code_out,
    output reg         code_valid,
    output reg         fix_valid,
    output reg  [8:0]  fix_index,
    output reg  [11:0] fix_value,
    output reg         block_done,
    output reg         block_clean,
    output reg         block_corrected,
    output reg         block_uncorrectable,
    output reg  [2:0]  error_symbols
);

    localparam [2:0] ST_DATA  = 3'h0;  // taking sector bytes
    localparam [2:0] ST_PAD   = 3'h1;  // last symbol, a third filled
    localparam [2:0] ST_PAR   = 3'h2;  // stored check symbols
    localparam [2:0] ST_BM    = 3'h3;  // locator iterations
    localparam [2:0] ST_SOLVE = 3'h4;  // classify and start search
    localparam [2:0] ST_SCAN  = 3'h5;  // root search
    localparam [2:0] ST_INV   = 3'h6;  // waiting on inverter

    // shift-and-add multiply modulo the field polynomial
    function [11:0] gf_mul;
        input [11:0] a;
        input [11:0] b;
        reg   [11:0] p;
        reg   [11:0] x;
        integer      k;
        begin
            p = 12'h000;
            x = a;
            for (k = 0; k < 12; k = k + 1) begin
                if (b[k])
                    p = p ^ x;
                x = x[11] ? ({x[10:0], 1'b0} ^ `GF_POLY_LOW)
                          : {x[10:0], 1'b0};
            end
            gf_mul = p;
        end
    endfunction

    // alpha to a power, evaluated at elaboration only
    function [11:0] alpha_pow;
        input integer e;
        integer       k;
        integer       m;
        reg   [11:0]  x;
        begin
            m = e % `GF_ORDER;
            x = 12'h001;
            for (k = 0; k < m; k = k + 1)
                x = x[11] ? ({x[10:0], 1'b0} ^ `GF_POLY_LOW)
                          : {x[10:0], 1'b0};
            alpha_pow = x;
        end
    endfunction

    // generator product of (x + alpha^i), i = 0..5; x^6 term implied
    function [83:0] gen_poly;
        input integer dummy;
        reg   [83:0]  g;
        reg   [11:0]  r;
        integer       i;
        integer       j;
        begin
            g = 84'h1;
            for (i = 0; i < `CHECK_SYMS; i = i + 1) begin
                r = alpha_pow(i + dummy);
                for (j = 6; j > 0; j = j - 1)
                    g[j*12 +: 12] = g[(j-1)*12 +: 12]
                                  ^ gf_mul(g[j*12 +: 12], r);
                g[11:0] = gf_mul(g[11:0], r);
            end
            gen_poly = g;
        end
    endfunction

    localparam [83:0] gen_coef = gen_poly(0);
    // alpha^i: syndrome step and search step per term
    localparam [71:0] step_tab = {alpha_pow(5), alpha_pow(4),
        alpha_pow(3), alpha_pow(2), alpha_pow(1), alpha_pow(0)};
    // alpha^(-347 i): search starts at the first symbol sent
    localparam [47:0] chien_tab = {
        alpha_pow(`GF_ORDER - (`CHIEN_SPAN * 3) % `GF_ORDER),
        alpha_pow(`GF_ORDER - (`CHIEN_SPAN * 2) % `GF_ORDER),
        alpha_pow(`GF_ORDER - `CHIEN_SPAN), alpha_pow(0)};

    reg [2:0]  state;       // sequencer
    reg [8:0]  byte_cnt;    // byte within the sector
    reg [1:0]  phase;       // byte within a 3-byte, 2-symbol group
    reg [7:0]  hold;        // bits waiting for their symbol
    reg        dec_blk;     // this block is a read-back check
    reg [71:0] par_sh;      // stored check field, shifted out
    reg [2:0]  step;        // check-symbol and iteration counter
    reg [11:0] lfsr [0:5];  // encoder remainder
    reg [11:0] syn  [0:5];  // syndromes at alpha^0..alpha^5
    reg [11:0] lam  [0:6];  // error locator
    reg [11:0] bb   [0:6];  // correction polynomial
    reg [11:0] gam;         // previous discrepancy
    reg [2:0]  lsize;       // locator length
    reg [11:0] tt   [0:3];  // locator terms at current position
    reg [11:0] uu   [0:2];  // evaluator terms at current position
    reg [8:0]  pos;         // symbol index under search
    reg        pass;        // 0 counts roots, 1 reports them
    reg [8:0]  roots;       // roots seen in counting pass
    reg [11:0] saved_u;     // evaluator value at the root
    reg [8:0]  saved_pos;   // index of the root
    reg        inv_start;   // inverter kick
    reg [11:0] inv_op;      // derivative term to invert

    wire        inv_done;
    wire [11:0] inv_res;

    reg        sym_go;      // a symbol enters this cycle
    reg        data_sym;    // it is a data symbol
    reg [11:0] sym;
    reg [11:0] fb;
    reg [11:0] next_lfsr [0:5];
    reg [71:0] next_code;
    reg [11:0] delta;
    reg [11:0] next_lam [0:6];
    reg [11:0] next_bb  [0:6];
    reg [11:0] next_gam;
    reg [2:0]  next_lsize;
    reg [11:0] om [0:2];    // evaluator, locator times syndromes
    reg [11:0] tsum;
    reg [11:0] usum;
    reg        root;
    // one index per process: a shared index retriggers the other @* blocks
    integer    i;           // sequencer loops only
    integer    ei;          // encoder loop
    integer    li;          // locator loop
    integer    vi;          // evaluator loop, with k
    integer    k;

    assign byte_ready = (state == ST_DATA);

    // two symbols per three bytes; the 512th byte leaves a nibble
    always @* begin
        sym_go   = 1'b0;
        data_sym = 1'b0;
        sym      = 12'h000;
        case (state)
            ST_DATA: begin
                if (byte_valid && phase != 2'h0) begin
                    sym_go   = 1'b1;
                    data_sym = 1'b1;
                    sym = (phase == 2'h1) ? {hold, byte_data[7:4]}
                                          : {hold[3:0], byte_data};
                end
            end
            ST_PAD: begin // pad low bits with zero
                sym_go   = 1'b1;
                data_sym = 1'b1;
                sym      = {hold[3:0], 8'h00};
            end
            ST_PAR: begin
                sym_go = 1'b1;
                sym    = par_sh[71:60];
            end
            default: ;
        endcase
    end

    // encoder division by the generator, remainder is the check field
    always @* begin
        fb = sym ^ lfsr[5];
        for (ei = 0; ei < 6; ei = ei + 1) begin
            next_lfsr[ei] = gf_mul(fb, gen_coef[ei*12 +: 12]);
            if (ei > 0)
                next_lfsr[ei] = next_lfsr[ei] ^ lfsr[ei-1];
            next_code[ei*12 +: 12] = next_lfsr[ei];
        end
    end

    // one inversionless locator iteration; avoids a divider per step
    always @* begin
        delta = 12'h000;
        for (li = 0; li < 7; li = li + 1)
            if (li <= step)
                delta = delta ^ gf_mul(lam[li], syn[step - li]);
        for (li = 0; li < 7; li = li + 1) begin
            next_lam[li] = gf_mul(gam, lam[li]);
            if (li > 0)
                next_lam[li] = next_lam[li] ^ gf_mul(delta, bb[li-1]);
        end
        next_gam   = gam;
        next_lsize = lsize;
        if (delta != 12'h000 && {lsize, 1'b0} <= {1'b0, step}) begin
            next_gam   = delta;
            next_lsize = step + 3'h1 - lsize;
            for (li = 0; li < 7; li = li + 1)
                next_bb[li] = lam[li];
        end else begin
            for (li = 0; li < 7; li = li + 1)
                next_bb[li] = (li > 0) ? bb[li-1] : 12'h000;
        end
    end

    // evaluator and search sums; sum of odd terms is the derivative
    always @* begin
        for (k = 0; k < 3; k = k + 1) begin
            om[k] = 12'h000;
            for (vi = 0; vi <= k; vi = vi + 1)
                om[k] = om[k] ^ gf_mul(lam[vi], syn[k-vi]);
        end
        tsum = tt[0] ^ tt[1] ^ tt[2] ^ tt[3];
        usum = uu[0] ^ uu[1] ^ uu[2];
        root = (tsum == 12'h000);
    end

    gf_inverse_unit inverter (
        .core_clk (core_clk),
        .reset    (reset),
        .start    (inv_start),
        .operand  (inv_op),
        .done     (inv_done),
        .result   (inv_res)
    );

    // main sequencer: framing, syndromes, locator, search, verdict
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= ST_DATA;
            byte_cnt <= 9'h000;
            phase <= 2'h0;
            hold <= 8'h00;
            dec_blk <= 1'b0;
            par_sh <= 72'h0;
            step <= 3'h0;
            gam <= 12'h001;
            lsize <= 3'h0;
            pos <= 9'h000;
            pass <= 1'b0;
            roots <= 9'h000;
            saved_u <= 12'h000;
            saved_pos <= 9'h000;
            inv_start <= 1'b0;
            inv_op <= 12'h000;
            code_out <= 72'h0;
            code_valid <= 1'b0;
            fix_valid <= 1'b0;
            fix_index <= 9'h000;
            fix_value <= 12'h000;
            block_done <= 1'b0;
            block_clean <= 1'b0;
            block_corrected <= 1'b0;
            block_uncorrectable <= 1'b0;
            error_symbols <= 3'h0;
            for (i = 0; i < 7; i = i + 1) begin
                lam[i] <= 12'h000;
                bb[i] <= 12'h000;
            end
            for (i = 0; i < 6; i = i + 1) begin
                lfsr[i] <= 12'h000;
                syn[i] <= 12'h000;
            end
            for (i = 0; i < 4; i = i + 1)
                tt[i] <= 12'h000;
            for (i = 0; i < 3; i = i + 1)
                uu[i] <= 12'h000;
        end else begin
            code_valid <= 1'b0;
            fix_valid <= 1'b0;
            block_done <= 1'b0;
            inv_start <= 1'b0;
            // horner step per symbol, check field included on read-back
            if (sym_go) begin
                for (i = 0; i < 6; i = i + 1)
                    syn[i] <= gf_mul(syn[i], step_tab[i*12 +: 12])
                            ^ sym;
                if (data_sym)
                    for (i = 0; i < 6; i = i + 1)
                        lfsr[i] <= next_lfsr[i];
            end
            case (state)
                ST_DATA: begin
                    if (byte_valid) begin
                        if (byte_cnt == 9'h000) begin // fresh block
                            dec_blk <= decode_mode;
                            for (i = 0; i < 6; i = i + 1) begin
                                lfsr[i] <= 12'h000;
                                syn[i] <= 12'h000;
                            end
                        end
                        hold <= byte_data;
                        byte_cnt <= byte_cnt + 9'h001;
                        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
                        if (byte_cnt == `LAST_BYTE) begin
                            state <= ST_PAD;
                            phase <= 2'h0;
                            par_sh <= code_in;
                        end
                    end
                end
                ST_PAD: begin
                    step <= 3'h0;
                    if (dec_blk) begin
                        state <= ST_PAR;
                    end else begin // encoder result after pad symbol
                        code_out <= next_code;
                        code_valid <= 1'b1;
                        state <= ST_DATA;
                    end
                end
                ST_PAR: begin
                    par_sh <= {par_sh[59:0], 12'h000};
                    step <= step + 3'h1;
                    if (step == `LAST_CHECK) begin
                        state <= ST_BM;
                        step <= 3'h0;
                        gam <= 12'h001;
                        lsize <= 3'h0;
                        for (i = 0; i < 7; i = i + 1) begin
                            lam[i] <= (i == 0) ? 12'h001 : 12'h000;
                            bb[i] <= (i == 0) ? 12'h001 : 12'h000;
                        end
                    end
                end
                ST_BM: begin
                    for (i = 0; i < 7; i = i + 1) begin
                        lam[i] <= next_lam[i];
                        bb[i] <= next_bb[i];
                    end
                    gam <= next_gam;
                    lsize <= next_lsize;
                    step <= step + 3'h1;
                    if (step == `BM_LAST)
                        state <= ST_SOLVE;
                end
                ST_SOLVE: begin
                    if (lsize == 3'h0) begin // all syndromes zero
                        block_done <= 1'b1;
                        block_clean <= 1'b1;
                        block_corrected <= 1'b0;
                        block_uncorrectable <= 1'b0;
                        error_symbols <= 3'h0;
                        state <= ST_DATA;
                    end else if (lsize > `CORR_LIMIT) begin
                        // four to six symbols: seen, not repaired
                        block_done <= 1'b1;
                        block_clean <= 1'b0;
                        block_corrected <= 1'b0;
                        block_uncorrectable <= 1'b1;
                        error_symbols <= lsize;
                        state <= ST_DATA;
                    end else begin
                        for (i = 0; i < 4; i = i + 1)
                            tt[i] <= gf_mul(lam[i], chien_tab[i*12 +: 12]);
                        for (i = 0; i < 3; i = i + 1)
                            uu[i] <= gf_mul(om[i], chien_tab[i*12 +: 12]);
                        pos <= 9'h000;
                        pass <= 1'b0;
                        roots <= 9'h000;
                        state <= ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    for (i = 0; i < 4; i = i + 1)
                        tt[i] <= gf_mul(tt[i], step_tab[i*12 +: 12]);
                    for (i = 0; i < 3; i = i + 1)
                        uu[i] <= gf_mul(uu[i], step_tab[i*12 +: 12]);
                    pos <= pos + 9'h001;
                    if (!pass) begin
                        roots <= roots + {8'h00, root};
                    end else if (root) begin // value = omega / derivative
                        inv_op <= tt[1] ^ tt[3];
                        inv_start <= 1'b1;
                        saved_u <= usum;
                        saved_pos <= pos;
                        state <= ST_INV;
                    end
                    if (pos == `LAST_POS) begin
                        if (!pass) begin
                            // miscount means more errors than the locator
                            if (roots + {8'h00, root} == {6'h00, lsize}) begin
                                pass <= 1'b1;
                                pos <= 9'h000;
                                for (i = 0; i < 4; i = i + 1)
                                    tt[i] <= gf_mul(lam[i],
                                                    chien_tab[i*12 +: 12]);
                                for (i = 0; i < 3; i = i + 1)
                                    uu[i] <= gf_mul(om[i],
                                                    chien_tab[i*12 +: 12]);
                            end else begin
                                block_done <= 1'b1;
                                block_clean <= 1'b0;
                                block_corrected <= 1'b0;
                                block_uncorrectable <= 1'b1;
                                error_symbols <= lsize;
                                state <= ST_DATA;
                            end
                        end else if (!root) begin
                            block_done <= 1'b1;
                            block_clean <= 1'b0;
                            block_corrected <= 1'b1;
                            block_uncorrectable <= 1'b0;
                            error_symbols <= lsize;
                            state <= ST_DATA;
                        end
                    end
                end
                ST_INV: begin
                    if (inv_done) begin
                        // 25-bit bursts touch three symbols at most
                        fix_valid <= 1'b1;
                        fix_index <= saved_pos;
                        fix_value <= gf_mul(inv_res, saved_u);
                        state <= ST_SCAN;
                        if (saved_pos == `LAST_POS) begin
                            block_done <= 1'b1;
                            block_clean <= 1'b0;
                            block_corrected <= 1'b1;
                            block_uncorrectable <= 1'b0;
                            error_symbols <= lsize;
                            state <= ST_DATA;
                        end
                    end
                end
                default: state <= ST_DATA;
            endcase
        end
    end

endmodule // sector_reed_solomon_codec

// ---- verification/sector_media.sv ----
// partner model: one flash page holding a sector and its check field
// assumes the bench fills, corrupts and reads it through hierarchy
module sector_media;
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  data [0:511]; // stored sector bytes
    logic [71:0] code;         // stored check field
    // flip one stream bit; the 8 pad bits after byte 511 are never stored
    task automatic corrupt(input int p);
        if (p < 4096) data[p/8][7-p%8] = ~data[p/8][7-p%8];
        else if (p >= 4104) code[71-(p-4104)] = ~code[71-(p-4104)];
    endtask
endmodule // sector_media

// ---- verification/sector_reed_solomon_codec_checker.sv ----
// checker: timing, refusal and verdict relations of the sector codec
// assumes it is bound to the codec top and sees its ports only
module sector_reed_solomon_codec_checker (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        decode_mode,
    input wire logic        byte_valid,
    input wire logic        byte_ready,
    input wire logic [71:0] code_out,
    input wire logic        code_valid,
    input wire logic        fix_valid,
    input wire logic [8:0]  fix_index,
    input wire logic [11:0] fix_value,
    input wire logic        block_done,
    input wire logic        block_clean,
    input wire logic        block_corrected,
    input wire logic        block_uncorrectable,
    input wire logic [2:0]  error_symbols
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic [8:0] taken; // bytes taken in this block
    logic       mode;  // mode held from byte 0
    wire take = byte_valid && byte_ready;
    wire last = take && taken == 9'h1ff;
    wire cur_mode = (taken == 9'h000) ? decode_mode : mode;
    // byte counter; wraps at 512 so it realigns on every block
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            taken <= 9'h000;
            mode  <= 1'b0;
        end else if (take) begin
            taken <= taken + 9'h001;
            mode  <= cur_mode;
        end
    end
    a_code_latency: assert property (last && !cur_mode |-> ##2 code_valid)
        else $error("check field late");
    a_refuse_last: assert property (last |=> !byte_ready ##1 (byte_ready != mode))
        else $error("byte taken after block end");
    a_encode_quiet: assert property (last && !cur_mode |=> !block_done [*8])
        else $error("verdict on encode");
    a_verdict_bound: assert property (last && cur_mode |-> ##[2:1000] block_done)
        else $error("no verdict");
    a_verdict_onehot: assert property (block_done |=> $onehot({block_clean, block_corrected, block_uncorrectable}))
        else $error("verdict flags not one-hot");
    a_clean_count: assert property (block_done |=> (!block_clean || error_symbols == 3'h0))
        else $error("clean with errors");
    a_corr_count: assert property (block_done |=> (!block_corrected || error_symbols inside {3'h1, 3'h2, 3'h3}))
        else $error("corrected count out of range");
    a_fix_range: assert property (fix_valid |-> fix_index <= 9'h15b && fix_value != 12'h000)
        else $error("bad correction event");
    c_clean: cover property (block_done ##1 block_clean);
    c_corr: cover property (block_done ##1 block_corrected);
    c_unc: cover property (block_done ##1 block_uncorrectable);
endmodule // sector_reed_solomon_codec_checker

bind sector_reed_solomon_codec sector_reed_solomon_codec_checker checker_i (.*);

// ---- verification/tb.sv ----
// self-checking bench: encode, corrupt the stored page, decode, compare
// assumes the codec reports fixes as symbol index and xor pattern
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, reset = 1, decode_mode = 0, byte_valid = 0;
    logic [7:0] byte_data = 8'h00;
    logic [71:0] code_in = 72'h0, code_out;
    logic byte_ready, code_valid, fix_valid, block_done;
    logic block_clean, block_corrected, block_uncorrectable;
    logic [8:0] fix_index;
    logic [11:0] fix_value;
    logic [2:0] error_symbols;
    logic [21:0] expq [$];       // notes: {verdict, index, value}
    logic [11:0] errmask [0:347]; // injected xor per symbol
    logic [31:0] seed = 32'h205f3749;
    int miscompares = 0, total_checks = 0, t, g, r, p, s;
    sector_media media_i ();
    sector_reed_solomon_codec sector_reed_solomon_codec_i (.*);
    always #10 core_clk = ~core_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string what, input logic [21:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic hit(input int b); // media fault plus expected pattern
        media_i.corrupt(b);
        if (b < 4096 || b >= 4104) errmask[b/12][11-b%12] ^= 1'b1;
    endtask
    task automatic syms(input int n); // spread so symbols stay distinct
        for (int i = 0; i < n; i++) begin
            s = (r + i * 117) % 348;
            hit(s * 12 + ((s == 341) ? r % 4 : (r + i) % 12));
        end
    endtask
    task automatic burst(input int b, n);
        for (int j = 0; j < n; j++) hit(b + j);
    endtask
    // random gaps hold byte_valid low one cycle each; refusals hold it low until byte_ready returns
    task automatic send_block(input logic m);
        for (int k = 0; k < 512; k++) begin
            @(negedge core_clk);
            for (g = 0; (byte_ready !== 1'b1 || rnd() % 4 == 0) && g < 3000; g++) begin
                byte_valid = 1'b0;
                @(negedge core_clk);
            end
            if (g == 3000) begin
                miscompares++;
                close_out();
            end
            decode_mode = m;
            byte_valid = 1'b1;
            byte_data = media_i.data[k];
            code_in = media_i.code;
        end
        @(negedge core_clk);
        byte_valid = 1'b0;
    endtask
    // monitor: oldest note against each event; fixes precede the verdict
    always @(posedge core_clk) begin
        logic [21:0] note, seen;
        if (fix_valid) begin
            note = (expq.size() > 0) ? expq.pop_front() : '1;
            check("fix", {1'b0, fix_index, fix_value}, note);
        end
        if (block_done) begin
            note = (expq.size() > 0) ? expq.pop_front() : '1;
            seen = {10'h200, 9'h0, block_uncorrectable, block_corrected, block_clean};
            check("verdict", seen, note);
        end
    end
    initial begin
        repeat (20) @(negedge core_clk);
        reset = 1'b0;
        for (t = 0; t < 20; t++) begin
            foreach (media_i.data[k]) media_i.data[k] = 8'(rnd());
            send_block(1'b0);
            for (g = 0; g < 20 && code_valid !== 1'b1; g++) @(negedge core_clk);
            if (g == 20) begin
                miscompares++;
                close_out();
            end
            media_i.code = code_out;
            foreach (errmask[k]) errmask[k] = 12'h000;
            r = rnd() % 348;
            p = rnd() % 2000;
            case (t % 10)
                1, 2, 3: syms(t % 10);
                4: burst(p, 25);
                5, 6, 7: syms(t % 10 - 1);
                8: burst(p, 61);
                9: begin
                    burst(p, 15);
                    burst(p + 2050, 15);
                end
                default: ;
            endcase
            if (t % 10 >= 5) expq.push_back(22'h200004);
            else if (t % 10 == 0) expq.push_back(22'h200001);
            else begin
                for (s = 0; s < 348; s++)
                    if (errmask[s] != 12'h000) expq.push_back({1'b0, 9'(s), errmask[s]});
                expq.push_back(22'h200002);
            end
            send_block(1'b1);
            for (g = 0; g < 3000 && expq.size() > 0; g++) @(negedge core_clk);
            if (g == 3000) begin
                miscompares++;
                close_out();
            end
        end
        close_out();
    end
endmodule // tb
